// >>> mcs_pkg.sv
// mcs_pkg: register map, fields, reset values and timing of the block.
// assumes a 125 MHz clock and 32-bit APB access.
package mcs_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX      = 8'h01;
  localparam logic [7:0] SAH_IDX       = 8'h02;
  localparam logic [7:0] SAL_IDX       = 8'h03;
  localparam logic [7:0] IRQ_STS_IDX   = 8'h0C;
  localparam logic [7:0] IRQ_MASK_IDX  = 8'h0D;
  localparam logic [7:0] STATUS_IDX    = 8'h0E;
  localparam logic [7:0] CTRL_ADDR     = {CTRL_IDX[5:0], 2'b00};
  localparam logic [7:0] SAH_ADDR      = {SAH_IDX[5:0], 2'b00};
  localparam logic [7:0] SAL_ADDR      = {SAL_IDX[5:0], 2'b00};
  localparam logic [7:0] IRQ_STS_ADDR  = {IRQ_STS_IDX[5:0], 2'b00};
  localparam logic [7:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX[5:0], 2'b00};
  localparam logic [7:0] STATUS_ADDR   = {STATUS_IDX[5:0], 2'b00};

  // control register fields
  localparam int DEFER_EN_BIT = 5;
  localparam int TX_ON_BIT    = 3;
  localparam int RX_ON_BIT    = 2;
  localparam logic [31:0] CTRL_RESET    = 32'h00000000;
  localparam logic [31:0] CTRL_WR_MASK  = 32'h0000002C;

  // station address registers
  localparam logic [31:0] SAH_RESET     = 32'h0000FFFF;
  localparam logic [31:0] SAH_WR_MASK   = 32'h0000FFFF;
  localparam logic [31:0] SAL_RESET     = 32'h0FFFFFFF;

  // eeprom locations of the address octets
  localparam logic [3:0] EE_LOC_L0 = 4'h1;
  localparam logic [3:0] EE_LOC_L1 = 4'h2;
  localparam logic [3:0] EE_LOC_L2 = 4'h3;
  localparam logic [3:0] EE_LOC_L3 = 4'h4;
  localparam logic [3:0] EE_LOC_H0 = 4'h5;
  localparam logic [3:0] EE_LOC_H1 = 4'h6;

  // interrupt status bits
  localparam int IRQ_W          = 3;
  localparam int IRQ_DEFER_BIT  = 0;
  localparam int IRQ_LOAD_BIT   = 1;
  localparam int IRQ_MATCH_BIT  = 2;

  // status register bits
  localparam int ST_DEFER_BIT   = 0;
  localparam int ST_INIT_BIT    = 1;
  localparam int ST_CRS_BIT     = 2;
  localparam int ST_RXFRM_BIT   = 3;

  // timing, in picoseconds
  localparam int CLK_PERIOD_PS   = 8000;
  localparam int BIT_TIME_100_PS = 10000;
  localparam int BIT_TIME_10_PS  = 100000;
  localparam int DEFER_LIMIT_BITS = 24288;
  localparam int ADDR_OCTETS     = 6;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_HDR  = 4'b0010,
    RX_PASS = 4'b0100,
    RX_DROP = 4'b1000
  } mcs_rx_state_type;

endpackage : mcs_pkg

// >>> mcs_defer_timer.sv
// mcs_defer_timer: counts deferral bit times, flags an excess once.
// assumes defer_active is a same-clock level.
`timescale 1ns/1ps
module mcs_defer_timer #(
  parameter int LIMIT_BITS = mcs_pkg::DEFER_LIMIT_BITS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        speed_100,
  input  wire logic        defer_active,
  input  wire logic        check_en,
  output logic             abort_pulse
);
  localparam logic [15:0] LIMIT = 16'(LIMIT_BITS);
  localparam logic [17:0] STEP  = 18'(mcs_pkg::CLK_PERIOD_PS);

  logic [16:0] acc_reg;
  logic [15:0] count_reg;
  logic        fired_reg;

  // bit-time enable from a phase accumulator; 8 ns does not divide 10 ns
  wire  [17:0] bit_ps  = speed_100 ? 18'(mcs_pkg::BIT_TIME_100_PS)
                                   : 18'(mcs_pkg::BIT_TIME_10_PS);
  wire  [17:0] acc_sum = {1'b0, acc_reg} + STEP;
  wire         tick    = acc_sum >= bit_ps;
  wire  [16:0] acc_next = tick ? 17'(acc_sum - bit_ps) : acc_sum[16:0];
  wire         over    = count_reg > LIMIT;
  wire         fire    = check_en && over && !fired_reg;

  always_ff @(posedge clk) begin
    if (rst || !defer_active) begin
      acc_reg   <= 17'h0;
      count_reg <= 16'h0;
      fired_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      if (tick && !over)
        count_reg <= count_reg + 16'h1;
      if (fire)
        fired_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      abort_pulse <= 1'b0;
    else
      abort_pulse <= fire;
  end

endmodule : mcs_defer_timer

// >>> mcs_octet_match.sv
// mcs_octet_match: compares a received octet with its address octet.
// assumes octet_idx is 0 for the first octet on the medium.
`timescale 1ns/1ps
module mcs_octet_match (
  input  wire logic [2:0]  octet_idx,
  input  wire logic [7:0]  rx_octet,
  input  wire logic [31:0] addr_low,
  input  wire logic [15:0] addr_high,
  output logic             equal
);
  logic [7:0] expect_octet;

  // low register byte 0 goes first, high register byte 1 goes last
  always_comb begin
    unique case (octet_idx)
      3'h0:    expect_octet = addr_low[7:0];
      3'h1:    expect_octet = addr_low[15:8];
      3'h2:    expect_octet = addr_low[23:16];
      3'h3:    expect_octet = addr_low[31:24];
      3'h4:    expect_octet = addr_high[7:0];
      3'h5:    expect_octet = addr_high[15:8];
      default: expect_octet = 8'h00;
    endcase
  end

  assign equal = (octet_idx < 3'h6) && (rx_octet == expect_octet);

endmodule : mcs_octet_match

// >>> mcs_mac_ctrl.sv
// mcs_mac_ctrl: control bits, station address, eeprom load,
// deferral check, tx/rx gating and address match.
// assumes APB, eeprom and frame paths on CLK;
// only carrier sense and speed strap are asynchronous.
// Notes on behaviour
// - with check on, abort the attempt after deferring over 24288 bit times
// - deferral counts while a frame is ready but carrier sense holds it off
// - deferral never accumulates; each new deferral restarts the count at zero
// - control bit 5 enables the check; clear means defer without limit
// - control bit 3 set lets queued frames go out; clear sends none
// - control bit 2 set accepts frames from the phy; clear accepts none
// - high address register holds bits 47:32 in 15:0, resets 0000FFFF
// - low address register holds bits 31:0, resets to its stated default
// - power-on load from eeprom happens only if a programmed eeprom is seen
// - high register bytes come from eeprom locations 0x05 and 0x06
// - low register bytes come from eeprom locations 0x01 through 0x04
// - low byte 0 is first octet received, high byte 1 the sixth
// - leftmost written address octet travels first on the medium
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module mcs_mac_ctrl #(
  parameter int DEFER_LIMIT_BITS = mcs_pkg::DEFER_LIMIT_BITS
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  output logic             IRQ,
  // eeprom controller
  input  wire logic        EE_PROGRAMMED,
  input  wire logic        EE_BYTE_VALID,
  input  wire logic [3:0]  EE_BYTE_LOC,
  input  wire logic [7:0]  EE_BYTE_DATA,
  input  wire logic        EE_DONE,
  // transmit side
  input  wire logic        CRS,
  input  wire logic        SPEED_100,
  input  wire logic        TX_FRAME_READY,
  input  wire logic        TX_BUSY,
  output logic             TX_START,
  output logic             TX_DEFER_ABORT,
  // receive side
  input  wire logic        RX_DV,
  input  wire logic        RX_BYTE_VALID,
  input  wire logic [7:0]  RX_BYTE,
  output logic             RX_OUT_VALID,
  output logic [7:0]       RX_OUT_BYTE,
  output logic             RX_OUT_END,
  output logic             RX_ADDR_MATCH
);


  // pin synchronisers
  logic crs_meta_reg;
  logic crs_sync_reg;
  logic spd_meta_reg;
  logic spd_sync_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      crs_meta_reg <= 1'b0;
      crs_sync_reg <= 1'b0;
      spd_meta_reg <= 1'b0;
      spd_sync_reg <= 1'b0;
    end else begin
      crs_meta_reg <= CRS;
      crs_sync_reg <= crs_meta_reg;
      spd_meta_reg <= SPEED_100;
      spd_sync_reg <= spd_meta_reg;
    end
  end


  // registers
  logic [31:0]                   ctrl_reg;
  logic [31:0]                   sah_reg;
  logic [31:0]                   sal_reg;
  logic [mcs_pkg::IRQ_W-1:0]     irq_sts_reg;
  logic [mcs_pkg::IRQ_W-1:0]     irq_mask_reg;
  logic                          init_done_reg;
  logic [31:0]                   prdata_reg;
  logic                          pslverr_reg;

  wire        deferral_limit_enable = ctrl_reg[mcs_pkg::DEFER_EN_BIT];
  wire        transmitter_on        = ctrl_reg[mcs_pkg::TX_ON_BIT];
  wire        receiver_on           = ctrl_reg[mcs_pkg::RX_ON_BIT];

  // apb decode
  wire        setup_ph  = PSEL && !PENABLE;
  wire        access_ph = PSEL && PENABLE;
  wire        wr_cyc    = access_ph && PWRITE;
  wire        hit_ctrl  = PADDR == mcs_pkg::CTRL_ADDR;
  wire        hit_sah   = PADDR == mcs_pkg::SAH_ADDR;
  wire        hit_sal   = PADDR == mcs_pkg::SAL_ADDR;
  wire        hit_ists  = PADDR == mcs_pkg::IRQ_STS_ADDR;
  wire        hit_imask = PADDR == mcs_pkg::IRQ_MASK_ADDR;
  wire        hit_stat  = PADDR == mcs_pkg::STATUS_ADDR;
  wire        hit_any   = hit_ctrl || hit_sah || hit_sal || hit_ists
                          || hit_imask || hit_stat;
  wire [31:0] strb_mask = {{8{PSTRB[3]}}, {8{PSTRB[2]}},
                           {8{PSTRB[1]}}, {8{PSTRB[0]}}};

  // eeprom byte steering; dropped unless a programmed part was detected
  wire        ee_take   = EE_BYTE_VALID && EE_PROGRAMMED;
  wire        ee_l0     = ee_take && EE_BYTE_LOC == mcs_pkg::EE_LOC_L0;
  wire        ee_l1     = ee_take && EE_BYTE_LOC == mcs_pkg::EE_LOC_L1;
  wire        ee_l2     = ee_take && EE_BYTE_LOC == mcs_pkg::EE_LOC_L2;
  wire        ee_l3     = ee_take && EE_BYTE_LOC == mcs_pkg::EE_LOC_L3;
  wire        ee_h0     = ee_take && EE_BYTE_LOC == mcs_pkg::EE_LOC_H0;
  wire        ee_h1     = ee_take && EE_BYTE_LOC == mcs_pkg::EE_LOC_H1;
  wire [31:0] ee_lmask  = {{8{ee_l3}}, {8{ee_l2}}, {8{ee_l1}}, {8{ee_l0}}};
  wire [31:0] ee_hmask  = {16'h0000, {8{ee_h1}}, {8{ee_h0}}};
  wire [31:0] ee_word   = {4{EE_BYTE_DATA}};

  // host write data merged with byte strobes
  wire [31:0] wmask_l   = (wr_cyc && hit_sal) ? strb_mask : 32'h0;
  wire [31:0] wmask_h   = (wr_cyc && hit_sah)
                          ? (strb_mask & mcs_pkg::SAH_WR_MASK) : 32'h0;
  wire [31:0] wmask_c   = (wr_cyc && hit_ctrl)
                          ? (strb_mask & mcs_pkg::CTRL_WR_MASK) : 32'h0;

  // eeprom bytes win over a simultaneous host write to the same byte
  wire [31:0] sal_next   = (sal_reg & ~(wmask_l | ee_lmask))
                           | (PWDATA & wmask_l & ~ee_lmask)
                           | (ee_word & ee_lmask);
  wire [31:0] sah_next   = (sah_reg & ~(wmask_h | ee_hmask))
                           | (PWDATA & wmask_h & ~ee_hmask)
                           | (ee_word & ee_hmask);
  wire [31:0] ctrl_next  = (ctrl_reg & ~wmask_c) | (PWDATA & wmask_c);

  // interrupt events, set wins over write-one-to-clear
  logic                       defer_abort;
  logic                       addr_match_pulse;
  wire [mcs_pkg::IRQ_W-1:0]   irq_set;
  wire [mcs_pkg::IRQ_W-1:0]   irq_clr = (wr_cyc && hit_ists && PSTRB[0])
                                        ? PWDATA[mcs_pkg::IRQ_W-1:0]
                                        : {mcs_pkg::IRQ_W{1'b0}};
  wire [mcs_pkg::IRQ_W-1:0]   irq_sts_next = (irq_sts_reg & ~irq_clr) | irq_set;

  assign irq_set[mcs_pkg::IRQ_DEFER_BIT] = defer_abort;
  assign irq_set[mcs_pkg::IRQ_LOAD_BIT]  = EE_DONE;
  assign irq_set[mcs_pkg::IRQ_MATCH_BIT] = addr_match_pulse;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_reg  <= mcs_pkg::CTRL_RESET;
      sah_reg   <= mcs_pkg::SAH_RESET;
      sal_reg   <= mcs_pkg::SAL_RESET;
    end else begin
      ctrl_reg  <= ctrl_next;
      sah_reg   <= sah_next;
      sal_reg   <= sal_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_sts_reg   <= {mcs_pkg::IRQ_W{1'b0}};
      irq_mask_reg  <= {mcs_pkg::IRQ_W{1'b0}};
      init_done_reg <= 1'b0;
    end else begin
      irq_sts_reg <= irq_sts_next;
      if (wr_cyc && hit_imask && PSTRB[0])
        irq_mask_reg <= PWDATA[mcs_pkg::IRQ_W-1:0];
      if (EE_DONE)
        init_done_reg <= 1'b1;
    end
  end


  // read path: data captured in the setup cycle, shown in the access cycle
  logic        rx_in_frame;
  logic        deferring;
  wire  [31:0] status_word = {28'h0, rx_in_frame, crs_sync_reg,
                              init_done_reg, deferring};
  wire  [31:0] rd_mux = hit_ctrl  ? ctrl_reg
                      : hit_sah   ? sah_reg
                      : hit_sal   ? sal_reg
                      : hit_ists  ? {29'h0, irq_sts_reg}
                      : hit_imask ? {29'h0, irq_mask_reg}
                      : hit_stat  ? status_word
                      : 32'h0;

  always_ff @(posedge CLK) begin
    if (RST) begin
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else if (setup_ph) begin
      prdata_reg  <= PWRITE ? 32'h0 : rd_mux;
      pslverr_reg <= !hit_any;
    end
  end

  assign PREADY  = 1'b1;
  assign PRDATA  = prdata_reg;
  assign PSLVERR = access_ph && pslverr_reg;
  assign IRQ     = |(irq_sts_reg & irq_mask_reg);


  // transmit gating and deferral
  logic abort_hold_reg;
  logic tx_start_reg;
  logic defer_abort_reg;

  wire tx_want = transmitter_on && TX_FRAME_READY && !TX_BUSY
                 && !abort_hold_reg;
  assign deferring = tx_want && crs_sync_reg;
  wire tx_go     = tx_want && !crs_sync_reg && !tx_start_reg;

  mcs_defer_timer #(
    .LIMIT_BITS   (DEFER_LIMIT_BITS)
  ) u_defer (
    .clk          (CLK),
    .rst          (RST),
    .speed_100    (spd_sync_reg),
    .defer_active (deferring),
    .check_en     (deferral_limit_enable),
    .abort_pulse  (defer_abort)
  );

  // the aborted frame is held off until the buffer withdraws it
  always_ff @(posedge CLK) begin
    if (RST) begin
      abort_hold_reg  <= 1'b0;
      tx_start_reg    <= 1'b0;
      defer_abort_reg <= 1'b0;
    end else begin
      if (defer_abort)
        abort_hold_reg <= 1'b1;
      else if (!TX_FRAME_READY)
        abort_hold_reg <= 1'b0;
      tx_start_reg    <= tx_go;
      defer_abort_reg <= defer_abort;
    end
  end

  assign TX_START       = tx_start_reg;
  assign TX_DEFER_ABORT = defer_abort_reg;


  // receive gating and destination address match
  mcs_pkg::mcs_rx_state_type rx_state_reg;
  mcs_pkg::mcs_rx_state_type rx_state_next;
  logic [2:0]       octet_reg;
  logic             all_eq_reg;
  logic             octet_eq;
  logic             out_valid_reg;
  logic [7:0]       out_byte_reg;
  logic             out_end_reg;
  logic             match_reg;
  logic             rx_dv_reg;

  mcs_octet_match u_match (
    .octet_idx (octet_reg),
    .rx_octet  (RX_BYTE),
    .addr_low  (sal_reg),
    .addr_high (sah_reg[15:0]),
    .equal     (octet_eq)
  );

  wire frame_start = RX_DV && !rx_dv_reg;
  wire hdr_byte    = rx_state_reg == mcs_pkg::RX_HDR && RX_BYTE_VALID;
  wire last_octet  = octet_reg == 3'(mcs_pkg::ADDR_OCTETS - 1);
  wire passing     = rx_state_reg == mcs_pkg::RX_HDR || rx_state_reg == mcs_pkg::RX_PASS;
  assign rx_in_frame      = passing;
  assign addr_match_pulse = match_reg;

  // enable sampled once per frame so a frame is never cut in half
  always_comb begin
    rx_state_next = rx_state_reg;
    unique case (rx_state_reg)
      mcs_pkg::RX_IDLE:
        if (frame_start)
          rx_state_next = receiver_on ? mcs_pkg::RX_HDR : mcs_pkg::RX_DROP;
      mcs_pkg::RX_HDR:
        if (!RX_DV)
          rx_state_next = mcs_pkg::RX_IDLE;
        else if (hdr_byte && last_octet)
          rx_state_next = mcs_pkg::RX_PASS;
      mcs_pkg::RX_PASS, mcs_pkg::RX_DROP:
        if (!RX_DV)
          rx_state_next = mcs_pkg::RX_IDLE;
      default:
        rx_state_next = mcs_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_state_reg <= mcs_pkg::RX_IDLE;
      rx_dv_reg    <= 1'b0;
      octet_reg    <= 3'h0;
      all_eq_reg   <= 1'b1;
      match_reg    <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_dv_reg    <= RX_DV;
      match_reg    <= hdr_byte && last_octet && all_eq_reg && octet_eq;
      if (frame_start) begin
        octet_reg  <= 3'h0;
        all_eq_reg <= 1'b1;
      end else if (hdr_byte) begin
        octet_reg  <= octet_reg + 3'h1;
        all_eq_reg <= all_eq_reg && octet_eq;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      out_valid_reg <= 1'b0;
      out_byte_reg  <= 8'h00;
      out_end_reg   <= 1'b0;
    end else begin
      out_valid_reg <= passing && RX_DV && RX_BYTE_VALID;
      out_end_reg   <= passing && !RX_DV;
      if (RX_BYTE_VALID)
        out_byte_reg <= RX_BYTE;
    end
  end

  assign RX_OUT_VALID  = out_valid_reg;
  assign RX_OUT_BYTE   = out_byte_reg;
  assign RX_OUT_END    = out_end_reg;
  assign RX_ADDR_MATCH = match_reg;

endmodule : mcs_mac_ctrl

// >>> mcs_mac_ctrl_chk.sv
// mcs_mac_ctrl_chk: port checks on transmit, deferral abort and receive.
// assumes CLK with synchronous active-high RST; bound into mcs_mac_ctrl.
`timescale 1ns/1ps
module mcs_mac_ctrl_chk #(
  parameter int DEFER_LIMIT_BITS = mcs_pkg::DEFER_LIMIT_BITS
) (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       CRS,
  input wire logic       TX_FRAME_READY,
  input wire logic       TX_BUSY,
  input wire logic       TX_START,
  input wire logic       TX_DEFER_ABORT,
  input wire logic       RX_DV,
  input wire logic       RX_BYTE_VALID,
  input wire logic [7:0] RX_BYTE,
  input wire logic       RX_OUT_VALID,
  input wire logic [7:0] RX_OUT_BYTE,
  input wire logic       RX_OUT_END,
  input wire logic       RX_ADDR_MATCH
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // a limit of 20 bit times already spans more than 16 cycles
  sequence s_long_defer;
    $past(CRS, 8) && $past(CRS, 16) && $past(TX_FRAME_READY, 8);
  endsequence
  sequence s_carrier_held;
    $past(CRS, 2) && $past(CRS, 3) && $past(CRS, 4) && $past(CRS, 5);
  endsequence
  property p_abort_cause;
    TX_DEFER_ABORT |-> s_long_defer;
  endproperty
  a_abort_cause: assert property (p_abort_cause)
    else $error("abort without a long deferral");
  property p_abort_once;
    TX_DEFER_ABORT |=> !TX_DEFER_ABORT;
  endproperty
  a_abort_once: assert property (p_abort_once)
    else $error("abort pulse longer than one cycle");
  property p_start_carrier;
    TX_START |-> not s_carrier_held;
  endproperty
  a_start_carrier: assert property (p_start_carrier)
    else $error("start while carrier held");
  property p_start_cause;
    TX_START |-> $past(TX_FRAME_READY) && !$past(TX_BUSY);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start without a ready idle transmitter");
  property p_start_once;
    TX_START |=> !TX_START;
  endproperty
  a_start_once: assert property (p_start_once)
    else $error("start in consecutive cycles");
  property p_rx_out;
    RX_OUT_VALID |-> $past(RX_BYTE_VALID) && $past(RX_DV) && RX_OUT_BYTE == $past(RX_BYTE);
  endproperty
  a_rx_out: assert property (p_rx_out)
    else $error("accepted byte does not follow input byte");
  property p_rx_end;
    RX_OUT_END |-> $past(RX_DV, 2) && !$past(RX_DV);
  endproperty
  a_rx_end: assert property (p_rx_end)
    else $error("frame end not after data valid fell");
  property p_match;
    RX_ADDR_MATCH |-> $past(RX_BYTE_VALID) ##1 !RX_ADDR_MATCH;
  endproperty
  a_match: assert property (p_match)
    else $error("match not a pulse after a byte");
endmodule : mcs_mac_ctrl_chk

bind mcs_mac_ctrl mcs_mac_ctrl_chk #(.DEFER_LIMIT_BITS(DEFER_LIMIT_BITS)) chk_u (
  .CLK, .RST, .CRS, .TX_FRAME_READY, .TX_BUSY, .TX_START, .TX_DEFER_ABORT, .RX_DV,
  .RX_BYTE_VALID, .RX_BYTE, .RX_OUT_VALID, .RX_OUT_BYTE, .RX_OUT_END, .RX_ADDR_MATCH);

// >>> mcs_far_model.sv
// mcs_far_model: eeprom controller and internal phy.
// assumes its tasks are called just after a rising clk edge.
`timescale 1ns/1ps
module mcs_far_model (
  input  wire logic  clk,
  output logic       ee_programmed,
  output logic       ee_byte_valid,
  output logic [3:0] ee_byte_loc,
  output logic [7:0] ee_byte_data,
  output logic       ee_done,
  output logic       crs,
  output logic       rx_dv,
  output logic       rx_byte_valid,
  output logic [7:0] rx_byte
);
  initial begin
    {ee_programmed, ee_byte_valid, ee_byte_loc, ee_byte_data, ee_done} = '0;
    {crs, rx_dv, rx_byte_valid, rx_byte} = '0;
  end
  // octets[47:40] travels first and sits at location 1
  task automatic ee_load(input logic prog, input logic [47:0] octets);
    ee_programmed <= prog;
    for (int i = 1; i <= 6; i++) begin
      ee_byte_valid <= 1'b1;
      ee_byte_loc   <= 4'(i);
      ee_byte_data  <= octets[55-8*i -: 8];
      @(posedge clk);
    end
    // released data flips so stale bytes never pass for valid ones
    ee_byte_valid <= 1'b0;
    ee_byte_data  <= ~ee_byte_data;
    ee_done       <= 1'b1;
    @(posedge clk);
    ee_done <= 1'b0;
  endtask : ee_load
  task automatic carrier(input logic v);
    crs <= v;
  endtask : carrier
  task automatic frame(input logic [63:0] b, input int n);
    rx_dv <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rx_byte_valid <= 1'b1;
      rx_byte       <= b[63-8*i -: 8];
      @(posedge clk);
    end
    rx_byte_valid <= 1'b0;
    rx_byte       <= ~rx_byte;
    rx_dv         <= 1'b0;
    @(posedge clk);
  endtask : frame
endmodule : mcs_far_model

// >>> mcs_mac_ctrl_tb.sv
// mcs_mac_ctrl_tb: directed apb, eeprom, receive and transmit scenarios.
// assumes mcs_far_model plays eeprom and phy; speed fixed at 100 Mb/s.
`timescale 1ns/1ps
module mcs_mac_ctrl_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tx_ready = 1'b0, tx_busy = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, tx_start, tx_abort, ee_prog, ee_bv, ee_done, crs;
  logic rx_dv, rx_bv, rx_ov, rx_end, rx_match;
  logic [3:0] ee_loc;
  logic [7:0] ee_data, rx_byte, rx_ob;
  int n_mismatch = 0, comparisons = 0;
  int cyc = 0, n_start = 0, n_abort = 0, abort_cyc = 0, n_rx = 0, n_match = 0, n_end = 0;

  always #4 clk = ~clk;

  mcs_far_model far_u (.clk(clk), .ee_programmed(ee_prog), .ee_byte_valid(ee_bv),
    .ee_byte_loc(ee_loc), .ee_byte_data(ee_data), .ee_done(ee_done), .crs(crs),
    .rx_dv(rx_dv), .rx_byte_valid(rx_bv), .rx_byte(rx_byte));
  mcs_mac_ctrl #(.DEFER_LIMIT_BITS(20)) dut_u (.CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .IRQ(irq),
    .EE_PROGRAMMED(ee_prog), .EE_BYTE_VALID(ee_bv), .EE_BYTE_LOC(ee_loc),
    .EE_BYTE_DATA(ee_data), .EE_DONE(ee_done), .CRS(crs), .SPEED_100(1'b1),
    .TX_FRAME_READY(tx_ready), .TX_BUSY(tx_busy), .TX_START(tx_start),
    .TX_DEFER_ABORT(tx_abort), .RX_DV(rx_dv), .RX_BYTE_VALID(rx_bv), .RX_BYTE(rx_byte),
    .RX_OUT_VALID(rx_ov), .RX_OUT_BYTE(rx_ob), .RX_OUT_END(rx_end),
    .RX_ADDR_MATCH(rx_match));

  // sample mid-cycle, clear of the launching edge
  always @(negedge clk) begin
    cyc++;
    if (tx_start === 1'b1) n_start++;
    if (tx_abort === 1'b1) begin
      n_abort++;
      abort_cyc = cyc;
    end
    if (rx_ov === 1'b1) n_rx++;
    if (rx_match === 1'b1) n_match++;
    if (rx_end === 1'b1) n_end++;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask : chk

  task automatic wait_for(ref int cnt, input int bound);
    int n;
    n = 0;
    while (cnt < 1 && n < bound) begin
      @(negedge clk);
      n++;
    end
    if (cnt < 1) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : wait_for

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(name, exp, q);
  endtask : rd

  task automatic rx_try(input logic [63:0] b, input int exp_rx, input int exp_m);
    n_rx = 0;
    n_match = 0;
    n_end = 0;
    @(posedge clk);
    far_u.frame(b, 8);
    repeat (2) @(posedge clk);
    chk("rx_bytes", 32'(exp_rx), 32'(n_rx));
    chk("addr_match", 32'(exp_m), 32'(n_match));
    chk("rx_end", 32'(exp_rx > 0), 32'(n_end));
  endtask : rx_try

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd("ctrl", mcs_pkg::CTRL_ADDR, 32'h0);
    rd("addr_high", mcs_pkg::SAH_ADDR, 32'h0000FFFF);
    rd("addr_low", mcs_pkg::SAL_ADDR, 32'h0FFFFFFF);
    @(posedge clk);
    far_u.ee_load(1'b0, 48'h123456789ABC);
    rd("addr_high_kept", mcs_pkg::SAH_ADDR, 32'h0000FFFF);
    rd("addr_low_kept", mcs_pkg::SAL_ADDR, 32'h0FFFFFFF);
    wr(mcs_pkg::SAH_ADDR, 32'hFFFF1234);
    rd("addr_high_wr", mcs_pkg::SAH_ADDR, 32'h00001234);
    wr(mcs_pkg::SAL_ADDR, 32'hA1B2C3D4);
    rd("addr_low_wr", mcs_pkg::SAL_ADDR, 32'hA1B2C3D4);
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped_data", 32'h0, q);
    chk("unmapped_err", 32'h1, 32'(e));
  endtask : t_regs

  task automatic t_eeprom();
    wr(mcs_pkg::IRQ_STS_ADDR, 32'h7);
    wr(mcs_pkg::IRQ_MASK_ADDR, 32'h2);
    @(posedge clk);
    far_u.ee_load(1'b1, 48'h123456789ABC);
    rd("addr_low_ee", mcs_pkg::SAL_ADDR, 32'h78563412);
    rd("addr_high_ee", mcs_pkg::SAH_ADDR, 32'h0000BC9A);
    chk("irq_set", 32'h1, 32'(irq));
    wr(mcs_pkg::IRQ_STS_ADDR, 32'h2);
    @(negedge clk);
    chk("irq_clear", 32'h0, 32'(irq));
    wr(mcs_pkg::IRQ_MASK_ADDR, 32'h0);
  endtask : t_eeprom

  task automatic t_rx();
    wr(mcs_pkg::CTRL_ADDR, 32'h4);
    rx_try(64'h123456789ABC5A5A, 8, 1);
    rx_try(64'hBC9A785634125A5A, 8, 0);
    wr(mcs_pkg::CTRL_ADDR, 32'h0);
    rx_try(64'h123456789ABC5A5A, 0, 0);
  endtask : t_rx

  task automatic t_tx();
    n_start = 0;
    @(posedge clk);
    tx_ready <= 1'b1;
    repeat (20) @(posedge clk);
    chk("tx_held", 32'h0, 32'(n_start));
    wr(mcs_pkg::CTRL_ADDR, 32'h8);
    wait_for(n_start, 20);
    @(posedge clk);
    tx_busy <= 1'b1;
    tx_ready <= 1'b0;
    repeat (3) @(posedge clk);
    tx_busy <= 1'b0;
  endtask : t_tx

  task automatic t_defer();
    int t0;
    wr(mcs_pkg::IRQ_STS_ADDR, 32'h7);
    @(posedge clk);
    far_u.carrier(1'b1);
    repeat (3) @(posedge clk);
    tx_ready <= 1'b1;
    n_start = 0;
    n_abort = 0;
    repeat (100) @(posedge clk);
    chk("no_abort", 32'h0, 32'(n_abort));
    chk("deferring", 32'h0, 32'(n_start));
    wr(mcs_pkg::CTRL_ADDR, 32'h28);
    wait_for(n_abort, 20);
    rd("irq_status", mcs_pkg::IRQ_STS_ADDR, 32'h1);
    @(posedge clk);
    tx_ready <= 1'b0;
    repeat (3) @(posedge clk);
    tx_ready <= 1'b1;
    n_abort = 0;
    repeat (20) @(posedge clk);
    tx_busy <= 1'b1;
    repeat (5) @(posedge clk);
    tx_busy <= 1'b0;
    t0 = cyc;
    wait_for(n_abort, 80);
    // 21 bit times of 10 ns need at least 26 cycles
    chk("defer_restart", 32'h1, 32'(abort_cyc - t0 >= 26));
    chk("defer_bound", 32'h1, 32'(abort_cyc - t0 <= 40));
    @(posedge clk);
    far_u.carrier(1'b0);
    tx_ready <= 1'b0;
  endtask : t_defer

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_eeprom();
    t_rx();
    t_tx();
    t_defer();
    repeat (5) @(posedge clk);
    print_verdict();
  end
endmodule : mcs_mac_ctrl_tb
